// File: hdl/serial_lan_irq_defines.svh
// Address map, field positions, reset values and timing counts for the
// serial and LAN interrupt support block.
// Included by its bare name; holds definitions only.
`ifndef SERIAL_LAN_IRQ_DEFINES_SVH
`define SERIAL_LAN_IRQ_DEFINES_SVH

// Byte addresses of the registers on the local bus
`define ADDR_MODEM_VECTOR 32'hFFF42023
`define ADDR_TRANSMIT_VECTOR 32'hFFF42025
`define ADDR_RECEIVE_VECTOR 32'hFFF42027
`define ADDR_LAN_ERR 32'hFFF42028
`define ADDR_LAN_CTL 32'hFFF4202A
`define ADDR_LAN_BERR 32'hFFF4202B

// Codes driven on the acknowledge address lines
`define ACK_CODE_MODEM 8'h01
`define ACK_CODE_TRANSMIT 8'h02
`define ACK_CODE_RECEIVE 8'h03
`define ACK_CODE_IDLE 8'h00

// LAN DMA error status byte
`define ERR_CLEAR_BIT 0
`define ERR_LTO_BIT 1
`define ERR_VME_BIT 2
`define ERR_PAR_BIT 3
`define ERR_RESET 3'h0

// LAN interrupt control and bus error control bytes
`define CTL_POLARITY_BIT 7
`define CTL_EDGE_BIT 6
`define CTL_STATUS_BIT 5
`define CTL_ENABLE_BIT 4
`define CTL_CLEAR_BIT 3
`define BERR_SNOOP_MSB 7
`define BERR_SNOOP_LSB 6
`define LEVEL_MSB 2
`define CTL_WRITE_MASK 8'hD7
`define CTL_RESET 8'h00
`define BERR_RESET 8'h00

// Local bus timeout for a vector fetch
`define CLK_PERIOD_NS 40
`define LB_TIMEOUT_NS 10240
`define LB_TIMEOUT_CYCLES ((`LB_TIMEOUT_NS) / (`CLK_PERIOD_NS))

`endif

// File: hdl/serial_lan_irq_pkg.sv
// Types shared by the serial and LAN interrupt support block.
// Assumes nothing of its surroundings.
`default_nettype none

package serial_lan_irq_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_RELEASE = 2'b10
    } bus_state_t;

    typedef logic [7:0] byte_t;

endpackage : serial_lan_irq_pkg

`default_nettype wire

// File: hdl/pin_sync3.sv
// Three-stage synchroniser for inputs arriving from pins.
// The output changes only once the second and third stages agree.
`default_nettype none

module pin_sync3
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Pin side and filtered result
    input wire logic [WIDTH-1:0] PIN,
    output logic [WIDTH-1:0] Q
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Stage one feeds only stage two, so metastability stays contained
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            Q <= '0;
        end
        else
        begin
            stage1 <= PIN;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                Q <= stage3;
        end
    end

endmodule : pin_sync3

`default_nettype wire

// File: hdl/irq_request.sv
// Turns an interrupt condition and its programmed level into a request level.
// Level zero never requests; the output is registered.
`default_nettype none

module irq_request
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Condition and programmed level
    input wire logic ACTIVE,
    input wire logic [2:0] LEVEL,
    output logic [2:0] REQ_LEVEL
);

    logic [2:0] next_req_level;

    assign next_req_level = ACTIVE ? LEVEL : 3'h0;

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            REQ_LEVEL <= 3'h0;
        else
            REQ_LEVEL <= next_req_level;
    end

endmodule : irq_request

`default_nettype wire

// File: hdl/serial_lan_irq_support.sv
// Serial pseudo vector fetch registers and LAN error and interrupt registers.
// Assumes one local-bus cycle at a time, opened by a one-cycle LB_SEL strobe,
// and a serial controller that holds SER_VECTOR stable while SER_ACK_DONE is high.
// Operation
// - Reading a vector register starts an acknowledge cycle with code 01, 02 or 03.
// - The returned vector goes onto the read data in the same cycle that transfer_ack is raised.
// - The fetch is a plain read locally and an acknowledge cycle serially.
// - With no interrupt and the timer enabled, the fetch ends with transfer_error_ack.
// - Each vector register holds the vector of its most recent fetch.
// - Writing one to the clear bit zeroes the three error flags; it reads zero.
// - A LAN DMA error sets exactly the flag of its cause, clearing the rest.
// - A LAN DMA error of unknown cause clears all three flags.
// - The request level field picks the LAN interrupt level; zero requests nothing.
// - In edge mode the clear bit drops the LAN status; it always reads zero.
// - The enable bit lets the LAN interrupt through when set.
// - When enabled, LAN status follows the qualified pin in level mode or latches its rise in edge mode; it requests at the programmed level.
// - The edge select bit chooses edge or level sensitivity.
// - Polarity zero triggers on rise or high, one on fall or low.
// - During LAN DMA the snoop pins follow the snoop bits.
// - Writing one to the bus error clear bit drops its status; it reads zero.
`default_nettype none
`include "serial_lan_irq_defines.svh"

module serial_lan_irq_support
    import serial_lan_irq_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `LB_TIMEOUT_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Local bus register access
    input wire logic LB_SEL,
    input wire logic LB_WRITE,
    input wire logic [31:0] LB_ADDR,
    input wire logic [7:0] LB_WDATA,
    input wire logic LB_TIMER_EN,
    output logic [7:0] LB_RDATA,
    output logic LB_TA,
    output logic LB_TEA,
    // Serial controller acknowledge cycle
    output logic SER_IACK_REQ,
    output logic [7:0] SER_ACK_ADDR,
    input wire logic SER_ACK_DONE,
    input wire logic [7:0] SER_VECTOR,
    // LAN controller
    input wire logic LAN_INT_PIN,
    input wire logic LAN_DMA_ACTIVE,
    input wire logic LAN_DMA_TEA,
    input wire logic LAN_ERR_TIMEOUT,
    input wire logic LAN_ERR_VME,
    input wire logic LAN_ERR_PARITY,
    output logic [1:0] LAN_SNOOP,
    // Interrupt requests to the processor
    output logic [2:0] LAN_IRQ_LEVEL,
    output logic [2:0] LAN_BERR_IRQ_LEVEL
);

    bus_state_t state;
    bus_state_t next_state;
    logic [15:0] timer;
    logic [1:0] fetch_idx;
    byte_t vectors [0:2];
    logic [2:0] err_flags;
    logic [2:0] next_err_flags;
    byte_t lan_ctl;
    byte_t berr_ctl;
    logic lan_status;
    logic next_lan_status;
    logic berr_status;
    logic next_berr_status;
    logic qual_prev;
    logic lan_pin_sync;
    logic ack_done_sync;
    byte_t read_value;

    // Pin synchronisers
    pin_sync3 #(.WIDTH(1)) u_lan_int_sync
    (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .PIN(LAN_INT_PIN),
        .Q(lan_pin_sync)
    );

    pin_sync3 #(.WIDTH(1)) u_ack_done_sync
    (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .PIN(SER_ACK_DONE),
        .Q(ack_done_sync)
    );

    // Address decode
    wire hit_modem = LB_ADDR == `ADDR_MODEM_VECTOR;
    wire hit_transmit = LB_ADDR == `ADDR_TRANSMIT_VECTOR;
    wire hit_receive = LB_ADDR == `ADDR_RECEIVE_VECTOR;
    wire hit_vector = hit_modem | hit_transmit | hit_receive;
    wire hit_err = LB_ADDR == `ADDR_LAN_ERR;
    wire hit_ctl = LB_ADDR == `ADDR_LAN_CTL;
    wire hit_berr = LB_ADDR == `ADDR_LAN_BERR;
    wire idle = state == ST_IDLE;
    wire take = LB_SEL & idle;
    wire fetch_start = take & ~LB_WRITE & hit_vector;
    wire plain_access = take & ~fetch_start;
    wire wr_err = take & LB_WRITE & hit_err;
    wire wr_ctl = take & LB_WRITE & hit_ctl;
    wire wr_berr = take & LB_WRITE & hit_berr;
    wire [1:0] start_idx = hit_modem ? 2'h0 : (hit_transmit ? 2'h1 : 2'h2);
    wire fetch_done = (state == ST_FETCH) & ack_done_sync;
    wire timer_end = timer == 16'(TIMEOUT_CYCLES - 1);
    wire fetch_timeout = (state == ST_FETCH) & ~ack_done_sync & LB_TIMER_EN & timer_end;

    // acknowledge code per vector type; relies on matching codes
    assign SER_ACK_ADDR = (state == ST_FETCH) ?
        ((fetch_idx == 2'h0) ? `ACK_CODE_MODEM :
        ((fetch_idx == 2'h1) ? `ACK_CODE_TRANSMIT : `ACK_CODE_RECEIVE)) : `ACK_CODE_IDLE;
    // acknowledge cycle runs while the local read waits
    assign SER_IACK_REQ = state == ST_FETCH;

    // Cycle sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (fetch_start)
                    next_state = ST_FETCH;
            ST_FETCH:
                if (fetch_done | fetch_timeout)
                    next_state = ST_RELEASE;
            ST_RELEASE:
                // Wait for the serial side to drop its done before the next cycle
                if (~ack_done_sync)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            state <= ST_IDLE;
            timer <= 16'h0000;
            fetch_idx <= 2'h0;
        end
        else
        begin
            state <= next_state;
            timer <= (state == ST_FETCH) ? timer + 16'h0001 : 16'h0000;
            if (fetch_start)
                fetch_idx <= start_idx;
        end
    end

    // vector store, no reset since its content is undefined until a fetch
    always_ff @(posedge CLK)
    begin
        if (fetch_done)
            vectors[fetch_idx] <= SER_VECTOR;
    end

    // Register readback; clear bits read zero
    assign read_value = hit_err ? {4'h0, err_flags, 1'b0} :
        hit_ctl ? ((lan_ctl & `CTL_WRITE_MASK) | {2'h0, lan_status, 5'h00}) :
        hit_berr ? ((berr_ctl & `CTL_WRITE_MASK) | {2'h0, berr_status, 5'h00}) : 8'h00;

    // vector is placed on the data lines with transfer_ack
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            LB_RDATA <= 8'h00;
            LB_TA <= 1'b0;
            LB_TEA <= 1'b0;
        end
        else
        begin
            LB_TA <= plain_access | fetch_done;
            // fetch with no answer and the timer enabled ends in an error acknowledge
            LB_TEA <= fetch_timeout;
            if (fetch_done)
                LB_RDATA <= SER_VECTOR;
            else if (plain_access)
                LB_RDATA <= LB_WRITE ? 8'h00 : read_value;
        end
    end

    // the cause of a DMA error is recorded exclusively, lto first
    // unknown cause leaves no flag set
    // clear bit, loses to a DMA error in the same cycle
    always_comb
    begin
        next_err_flags = err_flags;
        if (LAN_DMA_TEA)
        begin
            if (LAN_ERR_TIMEOUT)
                next_err_flags = 3'b001;
            else if (LAN_ERR_VME)
                next_err_flags = 3'b010;
            else if (LAN_ERR_PARITY)
                next_err_flags = 3'b100;
            else
                next_err_flags = 3'b000;
        end
        else if (wr_err & LB_WDATA[`ERR_CLEAR_BIT])
            next_err_flags = 3'b000;
    end

    // polarity turns the pin into an active-high condition
    wire lan_qualified = lan_pin_sync ^ lan_ctl[`CTL_POLARITY_BIT];
    wire lan_rise = lan_qualified & ~qual_prev;
    wire edge_mode = lan_ctl[`CTL_EDGE_BIT];
    // enable bit qualifies the LAN interrupt
    wire lan_enable = lan_ctl[`CTL_ENABLE_BIT];
    // clear acts only with edge mode set in the same write
    wire lan_clear = wr_ctl & LB_WDATA[`CTL_CLEAR_BIT] & LB_WDATA[`CTL_EDGE_BIT];
    wire berr_clear = wr_berr & LB_WDATA[`CTL_CLEAR_BIT];

    // edge latches with set winning over clear, level tracks the pin
    always_comb
    begin
        if (edge_mode)
            next_lan_status = (lan_rise & lan_enable) | (lan_status & ~lan_clear);
        else
            next_lan_status = lan_qualified & lan_enable;
    end

    // bus error status, set wins over clear
    assign next_berr_status = LAN_DMA_TEA | (berr_status & ~berr_clear);

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            err_flags <= `ERR_RESET;
            lan_ctl <= `CTL_RESET;
            berr_ctl <= `BERR_RESET;
            lan_status <= 1'b0;
            berr_status <= 1'b0;
            qual_prev <= 1'b0;
        end
        else
        begin
            err_flags <= next_err_flags;
            if (wr_ctl)
                lan_ctl <= LB_WDATA & `CTL_WRITE_MASK;
            if (wr_berr)
                berr_ctl <= LB_WDATA & `CTL_WRITE_MASK;
            lan_status <= next_lan_status;
            berr_status <= next_berr_status;
            qual_prev <= lan_qualified;
        end
    end

    // snoop pins follow the snoop bits during LAN DMA
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            LAN_SNOOP <= 2'h0;
        else
            LAN_SNOOP <= LAN_DMA_ACTIVE ? berr_ctl[`BERR_SNOOP_MSB:`BERR_SNOOP_LSB] : 2'h0;
    end

    // request at the programmed level, zero gives none
    // status qualified by enable drives the request
    irq_request u_lan_irq
    (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .ACTIVE(lan_status & lan_enable),
        .LEVEL(lan_ctl[`LEVEL_MSB:0]),
        .REQ_LEVEL(LAN_IRQ_LEVEL)
    );

    irq_request u_berr_irq
    (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .ACTIVE(berr_status & berr_ctl[`CTL_ENABLE_BIT]),
        .LEVEL(berr_ctl[`LEVEL_MSB:0]),
        .REQ_LEVEL(LAN_BERR_IRQ_LEVEL)
    );

    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    a_fetch_code_modem: assert property (fetch_start && hit_modem |=>
        SER_IACK_REQ && SER_ACK_ADDR == `ACK_CODE_MODEM)
        else $error("modem fetch did not drive code 01");

    a_fetch_code_receive: assert property (fetch_start && hit_receive |=>
        SER_IACK_REQ && SER_ACK_ADDR == `ACK_CODE_RECEIVE)
        else $error("receive fetch did not drive code 03");

    a_vector_to_bus: assert property (fetch_done |=>
        LB_TA && !LB_TEA && LB_RDATA == $past(SER_VECTOR))
        else $error("fetched vector not returned with transfer ack");

    a_fetch_holds_read: assert property (SER_IACK_REQ |-> !LB_TA && !LB_TEA)
        else $error("local cycle ended while acknowledge cycle active");

    a_fetch_timeout: assert property (fetch_timeout |=> LB_TEA && !LB_TA && !SER_IACK_REQ)
        else $error("fetch timeout did not end with error ack");

    a_vector_store: assert property (fetch_done |=>
        vectors[$past(fetch_idx)] == $past(SER_VECTOR))
        else $error("vector register not updated by fetch");

    a_err_clear: assert property (wr_err && LB_WDATA[0] && !LAN_DMA_TEA |=>
        err_flags == 3'b000)
        else $error("error clear did not zero flags");

    a_err_exclusive: assert property (LAN_DMA_TEA |=> $onehot0(err_flags))
        else $error("more than one error flag set");

    a_err_unknown: assert property (LAN_DMA_TEA && !LAN_ERR_TIMEOUT && !LAN_ERR_VME
        && !LAN_ERR_PARITY |=> err_flags == 3'b000)
        else $error("unknown error cause left a flag set");

    a_level_zero: assert property (lan_ctl[2:0] == 3'h0 ##1 lan_ctl[2:0] == 3'h0 |->
        LAN_IRQ_LEVEL == 3'h0)
        else $error("level zero produced a request");

    a_edge_clear: assert property (edge_mode && lan_clear && !lan_rise |=> !lan_status)
        else $error("edge clear did not drop status");

    a_disabled_quiet: assert property (!lan_enable ##1 !lan_enable |->
        LAN_IRQ_LEVEL == 3'h0)
        else $error("disabled interrupt produced a request");

    a_request_level: assert property (lan_status && lan_enable |=>
        LAN_IRQ_LEVEL == $past(lan_ctl[2:0]))
        else $error("request not at programmed level");

    a_edge_holds: assert property (edge_mode && lan_status && !lan_clear |=> lan_status)
        else $error("edge status lost without clear");

    a_level_tracks: assert property (!edge_mode && !lan_qualified |=> !lan_status)
        else $error("level mode status did not follow pin");

    a_snoop_drive: assert property (LAN_DMA_ACTIVE |=>
        LAN_SNOOP == $past(berr_ctl[7:6]))
        else $error("snoop pins differ from snoop bits");

    a_berr_clear: assert property (berr_clear && !LAN_DMA_TEA |=> !berr_status)
        else $error("bus error clear did not drop status");

    c_fetch_done: cover property (fetch_start ##[1:20] fetch_done);
    c_fetch_timeout: cover property (fetch_timeout);
    c_edge_irq: cover property (edge_mode && lan_rise && lan_enable);
    c_err_parity: cover property (LAN_DMA_TEA && LAN_ERR_PARITY && !LAN_ERR_TIMEOUT);

endmodule : serial_lan_irq_support

`default_nettype wire

// File: bench/serial_ctrl_model.sv
// Behavioural serial controller answering acknowledge cycles with a vector.
// Assumes the bench sets DELAY and VECTOR_IN between fetches; PENDING can also rise during a fetch.
`default_nettype none

module serial_ctrl_model
(
    // Clock
    input wire logic CLK,
    // Acknowledge cycle from the block
    input wire logic SER_IACK_REQ,
    input wire logic [7:0] SER_ACK_ADDR,
    output logic SER_ACK_DONE,
    output logic [7:0] SER_VECTOR,
    // Scenario controls
    input wire logic PENDING,
    input wire logic [3:0] DELAY,
    input wire logic [7:0] VECTOR_IN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] wait_cnt;
    logic code_match;
    assign code_match = (SER_ACK_ADDR >= 8'h01) && (SER_ACK_ADDR <= 8'h03);
    initial
    begin
        SER_ACK_DONE = 1'b0;
        SER_VECTOR = 8'h00;
        wait_cnt = 5'h00;
    end
    // No interrupt pending means no answer at all
    always @(negedge CLK)
    begin
        if (SER_IACK_REQ && PENDING && code_match)
        begin
            if (wait_cnt == {1'b0, DELAY})
            begin
                SER_ACK_DONE <= 1'b1;
                SER_VECTOR <= VECTOR_IN;
            end
            else
                wait_cnt <= wait_cnt + 5'h01;
        end
        else
        begin
            wait_cnt <= 5'h00;
            SER_ACK_DONE <= 1'b0;
            // Released bus keeps changing so stale data cannot match
            SER_VECTOR <= ~SER_VECTOR;
        end
    end
endmodule : serial_ctrl_model

`default_nettype wire

// File: bench/serial_lan_irq_support_tb.sv
// Self-checking bench for the serial and LAN interrupt support block.
// Assumes the serial controller model beside it; LAN pins driven here.
`default_nettype none
`include "serial_lan_irq_defines.svh"

module serial_lan_irq_support_tb
    import serial_lan_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Timeout kept above the slowest model answer, four sync cycles plus a delay of 15
    localparam int TMO = 32;
    logic CLK = 1'b0, SYS_RST = 1'b1, LB_SEL = 1'b0, LB_WRITE = 1'b0, LB_TIMER_EN = 1'b0;
    logic [31:0] LB_ADDR = 32'h0;
    logic [7:0] LB_WDATA = 8'h00, LB_RDATA, SER_ACK_ADDR, SER_VECTOR, VECTOR_IN = 8'h00;
    logic LB_TA, LB_TEA, SER_IACK_REQ, SER_ACK_DONE, PENDING = 1'b0;
    logic LAN_INT_PIN = 1'b0, LAN_DMA_ACTIVE = 1'b0, LAN_DMA_TEA = 1'b0;
    logic LAN_ERR_TIMEOUT = 1'b0, LAN_ERR_VME = 1'b0, LAN_ERR_PARITY = 1'b0;
    logic [1:0] LAN_SNOOP;
    logic [2:0] LAN_IRQ_LEVEL, LAN_BERR_IRQ_LEVEL, lvl;
    logic [3:0] DELAY = 4'h0;
    logic [31:0] vaddr [3] = '{`ADDR_MODEM_VECTOR, `ADDR_TRANSMIT_VECTOR, `ADDR_RECEIVE_VECTOR};
    logic [7:0] vcode [3] = '{`ACK_CODE_MODEM, `ACK_CODE_TRANSMIT, `ACK_CODE_RECEIVE};
    byte_t rd, seen_code, cdat;
    logic err, st, any;
    logic [1:0] snp;
    int error_cnt = 0, total_checks = 0, seed = 74184;

    always #20 CLK = ~CLK;

    serial_lan_irq_support #(.TIMEOUT_CYCLES(TMO)) u_serial_lan_irq_support (.CLK(CLK),
        .SYS_RST(SYS_RST), .LB_SEL(LB_SEL), .LB_WRITE(LB_WRITE), .LB_ADDR(LB_ADDR),
        .LB_WDATA(LB_WDATA), .LB_TIMER_EN(LB_TIMER_EN), .LB_RDATA(LB_RDATA), .LB_TA(LB_TA),
        .LB_TEA(LB_TEA), .SER_IACK_REQ(SER_IACK_REQ), .SER_ACK_ADDR(SER_ACK_ADDR),
        .SER_ACK_DONE(SER_ACK_DONE), .SER_VECTOR(SER_VECTOR), .LAN_INT_PIN(LAN_INT_PIN),
        .LAN_DMA_ACTIVE(LAN_DMA_ACTIVE), .LAN_DMA_TEA(LAN_DMA_TEA),
        .LAN_ERR_TIMEOUT(LAN_ERR_TIMEOUT), .LAN_ERR_VME(LAN_ERR_VME),
        .LAN_ERR_PARITY(LAN_ERR_PARITY), .LAN_SNOOP(LAN_SNOOP),
        .LAN_IRQ_LEVEL(LAN_IRQ_LEVEL), .LAN_BERR_IRQ_LEVEL(LAN_BERR_IRQ_LEVEL));

    serial_ctrl_model u_serial_ctrl_model (.CLK(CLK), .SER_IACK_REQ(SER_IACK_REQ),
        .SER_ACK_ADDR(SER_ACK_ADDR), .SER_ACK_DONE(SER_ACK_DONE), .SER_VECTOR(SER_VECTOR),
        .PENDING(PENDING), .DELAY(DELAY), .VECTOR_IN(VECTOR_IN));

    function automatic byte_t err_exp(input logic t, input logic v, input logic p);
        return t ? 8'h02 : v ? 8'h04 : p ? 8'h08 : 8'h00;
    endfunction : err_exp

    task automatic conclude;
        if (error_cnt == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task automatic chk(input string name, input byte_t exp, input byte_t got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask : wait_cyc

    // Strobe is one cycle wide, as the block takes it on a single edge
    task automatic lb_start(input logic wr, input logic [31:0] a, input byte_t d);
        @(negedge CLK);
        LB_SEL = 1'b1;
        LB_WRITE = wr;
        LB_ADDR = a;
        LB_WDATA = d;
        @(negedge CLK);
        LB_SEL = 1'b0;
    endtask : lb_start

    task automatic lb_wait(output byte_t r, output logic e);
        logic done;
        done = 1'b0;
        e = 1'b0;
        r = 8'h00;
        for (int n = 0; n < 300 && !done; n++)
        begin
            if (SER_IACK_REQ === 1'b1)
                seen_code = SER_ACK_ADDR;
            if (LB_TA === 1'b1 || LB_TEA === 1'b1)
            begin
                done = 1'b1;
                r = LB_RDATA;
                e = LB_TEA;
            end
            else
                @(negedge CLK);
        end
        if (!done)
        begin
            error_cnt++;
            conclude();
        end
    endtask : lb_wait

    task automatic lb_rd(input logic [31:0] a, output byte_t r);
        logic e;
        lb_start(1'b0, a, 8'h00);
        lb_wait(r, e);
    endtask : lb_rd

    task automatic lb_wr(input logic [31:0] a, input byte_t d);
        byte_t r;
        logic e;
        lb_start(1'b1, a, d);
        lb_wait(r, e);
    endtask : lb_wr

    initial
    begin
        wait_cyc(10);
        SYS_RST = 1'b0;
        lb_rd(`ADDR_LAN_ERR, rd);
        chk("err reset", 8'h00, rd);
        lb_rd(`ADDR_LAN_CTL, rd);
        chk("ctl reset", 8'h00, rd);
        lb_rd(`ADDR_LAN_BERR, rd);
        chk("berr reset", 8'h00, rd);
        lb_rd(32'hFFF42029, rd);
        chk("unmapped", 8'h00, rd);
        // Random vectors and answer delays over all three fetch registers
        PENDING = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            DELAY = 4'($random(seed));
            VECTOR_IN = 8'($random(seed));
            LB_TIMER_EN = i[0];
            seen_code = 8'h00;
            lb_start(1'b0, vaddr[i % 3], 8'h00);
            lb_wait(rd, err);
            chk("ack code", vcode[i % 3], seen_code);
            chk("vector", VECTOR_IN, rd);
            chk("fetch tea", 8'h00, {7'h0, err});
            chk("ack idle", `ACK_CODE_IDLE, SER_ACK_ADDR);
            chk("iack low", 8'h00, {7'h0, SER_IACK_REQ});
            wait_cyc(10);
        end
        PENDING = 1'b0;
        LB_TIMER_EN = 1'b1;
        lb_start(1'b0, vaddr[1], 8'h00);
        lb_wait(rd, err);
        chk("timeout tea", 8'h01, {7'h0, err});
        wait_cyc(10);
        // Timer off: the fetch must wait until an interrupt turns up
        LB_TIMER_EN = 1'b0;
        VECTOR_IN = 8'($random(seed));
        lb_start(1'b0, vaddr[2], 8'h00);
        any = 1'b0;
        repeat (3 * TMO)
        begin
            @(negedge CLK);
            any = any | LB_TA | LB_TEA;
        end
        chk("no answer", 8'h00, {7'h0, any});
        PENDING = 1'b1;
        lb_wait(rd, err);
        chk("late vector", VECTOR_IN, rd);
        wait_cyc(10);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge CLK);
            {LAN_ERR_TIMEOUT, LAN_ERR_VME, LAN_ERR_PARITY} = 3'(i);
            LAN_DMA_TEA = 1'b1;
            @(negedge CLK);
            LAN_DMA_TEA = 1'b0;
            lb_rd(`ADDR_LAN_ERR, rd);
            chk("err flags", err_exp(i[2], i[1], i[0]), rd);
        end
        lb_wr(`ADDR_LAN_ERR, 8'h01);
        lb_rd(`ADDR_LAN_ERR, rd);
        chk("err clear", 8'h00, rd);
        // Bus error status was set by the DMA errors above
        snp = 2'($random(seed));
        lvl = 3'($random(seed)) | 3'h1;
        lb_wr(`ADDR_LAN_BERR, {snp, 3'b010, lvl});
        lb_rd(`ADDR_LAN_BERR, rd);
        chk("berr set", {snp, 3'b110, lvl}, rd);
        chk("berr level", {5'h0, lvl}, {5'h0, LAN_BERR_IRQ_LEVEL});
        LAN_DMA_ACTIVE = 1'b1;
        wait_cyc(2);
        chk("snoop", {6'h0, snp}, {6'h0, LAN_SNOOP});
        LAN_DMA_ACTIVE = 1'b0;
        wait_cyc(2);
        chk("snoop idle", 8'h00, {6'h0, LAN_SNOOP});
        // Single snoop-line board: low snoop bit kept zero
        lb_wr(`ADDR_LAN_BERR, {2'b10, 3'b010, lvl});
        LAN_DMA_ACTIVE = 1'b1;
        wait_cyc(2);
        chk("snoop single", 8'h02, {6'h0, LAN_SNOOP});
        LAN_DMA_ACTIVE = 1'b0;
        wait_cyc(2);
        lb_wr(`ADDR_LAN_BERR, {snp, 3'b011, lvl});
        lb_rd(`ADDR_LAN_BERR, rd);
        chk("berr clear", {snp, 3'b010, lvl}, rd);
        // Level mode over polarity, pin level and enable
        for (int j = 0; j < 8; j++)
        begin
            lvl = 3'($random(seed)) | 3'h1;
            cdat = {j[0], 2'b00, j[2], 1'b0, lvl};
            lb_wr(`ADDR_LAN_CTL, cdat);
            LAN_INT_PIN = j[1];
            wait_cyc(8);
            st = j[2] & (j[1] ^ j[0]);
            lb_rd(`ADDR_LAN_CTL, rd);
            chk("level status", cdat | {2'b00, st, 5'h0}, rd);
            chk("level irq", st ? {5'h0, lvl} : 8'h00, {5'h0, LAN_IRQ_LEVEL});
            lb_wr(`ADDR_LAN_CTL, cdat | 8'h08);
            lb_rd(`ADDR_LAN_CTL, rd);
            chk("level clear", cdat | {2'b00, st, 5'h0}, rd);
        end
        LAN_INT_PIN = 1'b1;
        lb_wr(`ADDR_LAN_CTL, 8'h10);
        wait_cyc(8);
        chk("level zero", 8'h00, {5'h0, LAN_IRQ_LEVEL});
        for (int p = 0; p < 2; p++)
        begin
            LAN_INT_PIN = p[0];
            lvl = 3'($random(seed)) | 3'h1;
            cdat = {p[0], 3'b101, 1'b0, lvl};
            wait_cyc(8);
            lb_wr(`ADDR_LAN_CTL, cdat | 8'h08);
            LAN_INT_PIN = ~p[0];
            wait_cyc(8);
            LAN_INT_PIN = p[0];
            wait_cyc(8);
            lb_rd(`ADDR_LAN_CTL, rd);
            chk("edge latch", cdat | 8'h20, rd);
            chk("edge irq", {5'h0, lvl}, {5'h0, LAN_IRQ_LEVEL});
            lb_wr(`ADDR_LAN_CTL, cdat | 8'h08);
            lb_rd(`ADDR_LAN_CTL, rd);
            chk("edge clear", cdat, rd);
        end
        conclude();
    end
endmodule : serial_lan_irq_support_tb

`default_nettype wire
